// [accel_config_power_regs.sv]
// configuration and power register group of an acceleration sensor
// assumes reg_req_i comes from the serial interface core on sys_clk_i, one access per pulse;
// pins (serial_data_pin, measurement and interrupt levels from other clocks) are synchronised here
// Contract
// - self-test runs only while self-test enable bit 0 is set; reset 0x00.
// - self-test sign bit 0 negative excitation, 1 positive excitation.
// - self-test amplitude bit 0 low deflection, 1 high deflection.
// - in autoconfig mode bus-select 0 uses I2C, 1 disables I2C and uses SPI.
// - watchdog times out after 1.25 ms with period bit 0, 40 ms with 1.
// - watchdog watches serial data pin only in I2C mode with enable bit set.
// - offset-add enable adds each axis offset to filtered and unfiltered data.
// - three read/write 8-bit axis offset registers, non-volatile backed, reset 0x00.
// - four interface and offset bits held non-volatile backed, reading zero after reset.
// - power save 0 keeps fast clock on; 1 uses slow clock when idle.
// - in power save, FIFO reads refused unless self-wakeup set and interrupt seen.
// - power configuration register resets to 0x03.
// - command 0xA0 copies all non-volatile backed registers to non-volatile memory.
`timescale 1ns/1ps
`default_nettype none
module accel_config_power_regs #(
  parameter int WDT_SHORT_CYCLES = accel_cfg_pkg::WDT_SHORT_CYC,
  parameter int WDT_LONG_CYCLES  = accel_cfg_pkg::WDT_LONG_CYC
) (
  input  wire logic                    sys_clk_i,
  input  wire logic                    resetn_i,
  input  wire accel_cfg_pkg::reg_req_s reg_req_i,
  output logic [7:0]                   reg_rdata_o,
  input  wire logic                    autoconfig_mode_i,
  input  wire logic                    serial_data_pin_i,
  input  wire logic                    measure_busy_i,
  input  wire logic                    fifo_irq_i,
  input  wire logic                    fifo_rd_req_i,
  output logic                         fifo_rd_allow_o,
  output accel_cfg_pkg::cfg_s          cfg_o,
  output logic                         i2c_enable_o,
  output logic                         spi_enable_o,
  output logic                         fast_clk_en_o,
  output logic                         wdt_timeout_o,
  output logic                         nv_store_o,
  output logic [23:0]                  nv_image_o,
  output logic [7:0]                   nv_cfg_image_o,
  output logic [7:0]                   x_offset_o,
  output logic [7:0]                   y_offset_o,
  output logic [7:0]                   z_offset_o
);
  import accel_cfg_pkg::*;

  logic [7:0] self_test_r;
  logic [7:0] nv_cfg_r;
  logic [7:0] pwr_cfg_r;
  logic [7:0] offset_r [3];
  logic [2:0] sda_sync_r;
  logic [1:0] busy_sync_r;
  logic [1:0] irq_sync_r;
  logic       irq_seen_r;
  logic [21:0] wdt_cnt_r;
  logic        wdt_timeout_r;
  logic [7:0]  rdata_nxt;
  logic        wr_cfg;
  // one strobe each for self-test, non-volatile config and power config, plus one for the store command; offsets decode inline
  logic        wr_self_test;
  logic        wr_nv_cfg;
  logic        wr_pwr_cfg;
  logic        nv_prog_cmd;

  assign wr_cfg       = reg_req_i.wr_en;
  assign wr_self_test = wr_cfg && reg_req_i.addr == SELF_TEST_CONTROL_ADDR;
  assign wr_nv_cfg    = wr_cfg && reg_req_i.addr == NONVOLATILE_CONFIG_ADDR;
  assign wr_pwr_cfg   = wr_cfg && reg_req_i.addr == POWER_MODE_CONFIG_ADDR;
  assign nv_prog_cmd  = wr_cfg && reg_req_i.addr == COMMAND_ADDR && reg_req_i.wdata == CMD_NV_PROGRAM;

  // reserved bits masked at write, so reads give zero
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      self_test_r <= SELF_TEST_CONTROL_RST;
    end else if (wr_self_test) begin
      self_test_r <= reg_req_i.wdata & SELF_TEST_CONTROL_MASK;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nv_cfg_r <= NONVOLATILE_CONFIG_RST;
    end else if (wr_nv_cfg) begin
      nv_cfg_r <= reg_req_i.wdata & NONVOLATILE_CONFIG_MASK;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_cfg_r <= POWER_MODE_CONFIG_RST;
    end else if (wr_pwr_cfg) begin
      pwr_cfg_r <= reg_req_i.wdata & POWER_MODE_CONFIG_MASK;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_offset
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          offset_r[g] <= AXIS_OFFSET_RST;
        end else if (wr_cfg && reg_req_i.addr == X_AXIS_OFFSET_ADDR + 7'(g)) begin
          offset_r[g] <= reg_req_i.wdata;
        end
      end
    end
  endgenerate

  always_comb begin
    unique case (reg_req_i.addr)
      SELF_TEST_CONTROL_ADDR:  rdata_nxt = self_test_r;
      NONVOLATILE_CONFIG_ADDR: rdata_nxt = nv_cfg_r;
      X_AXIS_OFFSET_ADDR:      rdata_nxt = offset_r[0];
      Y_AXIS_OFFSET_ADDR:      rdata_nxt = offset_r[1];
      Z_AXIS_OFFSET_ADDR:      rdata_nxt = offset_r[2];
      POWER_MODE_CONFIG_ADDR:  rdata_nxt = pwr_cfg_r;
      default:                 rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_req_i.rd_en) begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  // one-cycle store pulse with a snapshot of every non-volatile backed byte
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nv_store_o     <= 1'b0;
      nv_image_o     <= 24'h000000;
      nv_cfg_image_o <= 8'h00;
    end else begin
      nv_store_o <= nv_prog_cmd;
      if (nv_prog_cmd) begin
        nv_image_o     <= {offset_r[2], offset_r[1], offset_r[0]};
        nv_cfg_image_o <= nv_cfg_r;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // idle-high start, so no false data edge right after reset
      sda_sync_r  <= 3'h7;
      busy_sync_r <= 2'h0;
      irq_sync_r  <= 2'h0;
    end else begin
      sda_sync_r  <= {sda_sync_r[1:0], serial_data_pin_i};
      busy_sync_r <= {busy_sync_r[0], measure_busy_i};
      irq_sync_r  <= {irq_sync_r[0], fifo_irq_i};
    end
  end

  // watchdog restarts on each serial data edge; idle holds it cleared
  logic        wdt_active;
  logic        sda_edge;
  logic [21:0] wdt_limit;
  assign wdt_active = i2c_enable_o && nv_cfg_r[WDT_EN_BIT];
  assign sda_edge   = sda_sync_r[2] != sda_sync_r[1];
  assign wdt_limit  = nv_cfg_r[WDT_SEL_BIT] ? 22'(WDT_LONG_CYCLES) : 22'(WDT_SHORT_CYCLES);

  // counter saturates one below the limit, so a held timeout never wraps back
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wdt_cnt_r <= 22'h000000;
    end else if (!wdt_active || sda_edge) begin
      wdt_cnt_r <= 22'h000000;
    end else if (wdt_cnt_r < wdt_limit - 22'h000001) begin
      wdt_cnt_r <= wdt_cnt_r + 22'h000001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wdt_timeout_r <= 1'b0;
    end else if (!wdt_active || sda_edge) begin
      wdt_timeout_r <= 1'b0;
    end else if (wdt_cnt_r >= wdt_limit - 22'h000001) begin
      wdt_timeout_r <= 1'b1;
    end
  end

  // interrupt wakes the fifo path; cleared once the interrupt is gone while power save or self-wakeup is off
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_seen_r <= 1'b0;
    end else if (irq_sync_r[1]) begin
      irq_seen_r <= 1'b1;
    end else if (!pwr_cfg_r[APS_BIT] || !pwr_cfg_r[FSW_BIT]) begin
      irq_seen_r <= 1'b0;
    end
  end

  assign fifo_rd_allow_o = fifo_rd_req_i &&
                           (!pwr_cfg_r[APS_BIT] || (pwr_cfg_r[FSW_BIT] && irq_seen_r));
  assign fast_clk_en_o   = !pwr_cfg_r[APS_BIT] || busy_sync_r[1];
  assign spi_enable_o    = autoconfig_mode_i && nv_cfg_r[SPI_EN_BIT];
  assign i2c_enable_o    = !spi_enable_o;
  assign wdt_timeout_o   = wdt_timeout_r;

  assign cfg_o.st_enable        = self_test_r[ST_EN_BIT];
  assign cfg_o.st_positive      = self_test_r[ST_SIGN_BIT];
  assign cfg_o.st_high_amp      = self_test_r[ST_AMP_BIT];
  assign cfg_o.spi_select       = nv_cfg_r[SPI_EN_BIT];
  assign cfg_o.wdt_enable       = nv_cfg_r[WDT_EN_BIT];
  assign cfg_o.wdt_long         = nv_cfg_r[WDT_SEL_BIT];
  assign cfg_o.offset_enable    = nv_cfg_r[OFF_EN_BIT];
  assign cfg_o.adv_power_save   = pwr_cfg_r[APS_BIT];
  assign cfg_o.fifo_self_wakeup = pwr_cfg_r[FSW_BIT];

  // zero offsets when disabled so the datapath can add unconditionally
  assign x_offset_o = nv_cfg_r[OFF_EN_BIT] ? offset_r[0] : 8'h00;
  assign y_offset_o = nv_cfg_r[OFF_EN_BIT] ? offset_r[1] : 8'h00;
  assign z_offset_o = nv_cfg_r[OFF_EN_BIT] ? offset_r[2] : 8'h00;

endmodule : accel_config_power_regs
`default_nettype wire

// [accel_cfg_pkg.sv]
// package for the acceleration sensor configuration register group
// assumes byte-wide register access from the primary serial interface core
package accel_cfg_pkg;

  localparam logic [6:0] SELF_TEST_CONTROL_ADDR = 7'h6D;
  localparam logic [6:0] NONVOLATILE_CONFIG_ADDR = 7'h70;
  localparam logic [6:0] X_AXIS_OFFSET_ADDR      = 7'h71;
  localparam logic [6:0] Y_AXIS_OFFSET_ADDR      = 7'h72;
  localparam logic [6:0] Z_AXIS_OFFSET_ADDR      = 7'h73;
  localparam logic [6:0] POWER_MODE_CONFIG_ADDR  = 7'h7C;
  localparam logic [6:0] COMMAND_ADDR            = 7'h7E;

  localparam logic [7:0] SELF_TEST_CONTROL_RST = 8'h00;
  localparam logic [7:0] NONVOLATILE_CONFIG_RST = 8'h00;
  localparam logic [7:0] AXIS_OFFSET_RST        = 8'h00;
  localparam logic [7:0] POWER_MODE_CONFIG_RST  = 8'h03;

  localparam logic [7:0] SELF_TEST_CONTROL_MASK = 8'h0D;
  localparam logic [7:0] NONVOLATILE_CONFIG_MASK = 8'h0F;
  localparam logic [7:0] POWER_MODE_CONFIG_MASK = 8'h03;

  localparam int ST_EN_BIT   = 0;
  localparam int ST_SIGN_BIT = 2;
  localparam int ST_AMP_BIT  = 3;
  localparam int SPI_EN_BIT  = 0;
  localparam int WDT_SEL_BIT = 1;
  localparam int WDT_EN_BIT  = 2;
  localparam int OFF_EN_BIT  = 3;
  localparam int APS_BIT     = 0;
  localparam int FSW_BIT     = 1;

  localparam logic [7:0] CMD_NV_PROGRAM = 8'hA0;

  localparam int CLK_HZ          = 50_000_000;
  localparam int WDT_SHORT_US    = 1250;
  localparam int WDT_LONG_US     = 40000;
  localparam int WDT_SHORT_CYC   = CLK_HZ / 1_000_000 * WDT_SHORT_US;
  localparam int WDT_LONG_CYC    = CLK_HZ / 1_000_000 * WDT_LONG_US;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic       st_enable;
    logic       st_positive;
    logic       st_high_amp;
    logic       spi_select;
    logic       wdt_enable;
    logic       wdt_long;
    logic       offset_enable;
    logic       adv_power_save;
    logic       fifo_self_wakeup;
  } cfg_s;

endpackage : accel_cfg_pkg

// [accel_config_power_regs_chk.sv]
// concurrent checks for the configuration register group
// bound to accel_config_power_regs, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module accel_config_power_regs_chk
  import accel_cfg_pkg::*;
(
  input wire logic                    sys_clk_i,
  input wire logic                    resetn_i,
  input wire accel_cfg_pkg::reg_req_s reg_req_i,
  input wire logic [7:0]              reg_rdata_o,
  input wire logic                    autoconfig_mode_i,
  input wire logic                    fifo_rd_allow_o,
  input wire accel_cfg_pkg::cfg_s     cfg_o,
  input wire logic                    i2c_enable_o,
  input wire logic                    spi_enable_o,
  input wire logic                    fast_clk_en_o,
  input wire logic                    wdt_timeout_o,
  input wire logic                    nv_store_o,
  input wire logic [7:0]              x_offset_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence nv_cmd_seq;
    reg_req_i.wr_en && reg_req_i.addr == COMMAND_ADDR && reg_req_i.wdata == CMD_NV_PROGRAM;
  endsequence
  sequence no_cmd_seq;
    !(reg_req_i.wr_en && reg_req_i.addr == COMMAND_ADDR && reg_req_i.wdata == CMD_NV_PROGRAM);
  endsequence
  sequence pulse_seq;
    nv_store_o ##1 !nv_store_o;
  endsequence
  spi_sel_a: assert property (spi_enable_o == (autoconfig_mode_i & cfg_o.spi_select))
    else $error("bus select wrong");
  i2c_sel_a: assert property (autoconfig_mode_i && !cfg_o.spi_select |-> i2c_enable_o && !spi_enable_o)
    else $error("i2c enable wrong");
  nv_pulse_a: assert property (nv_cmd_seq ##1 no_cmd_seq |-> pulse_seq)
    else $error("store pulse wrong");
  nv_quiet_a: assert property (no_cmd_seq |=> !nv_store_o)
    else $error("store pulse without command");
  offset_gate_a: assert property (!cfg_o.offset_enable |-> x_offset_o == 8'h00)
    else $error("offset not gated");
  fast_clk_a: assert property (!cfg_o.adv_power_save |-> fast_clk_en_o)
    else $error("fast clock off");
  fifo_refuse_a: assert property (cfg_o.adv_power_save && !cfg_o.fifo_self_wakeup |-> !fifo_rd_allow_o)
    else $error("fifo read allowed");
  wdt_idle_a: assert property (!(i2c_enable_o && cfg_o.wdt_enable) |=> !wdt_timeout_o)
    else $error("watchdog fired while off");
  rsvd_read_a: assert property (reg_req_i.rd_en && reg_req_i.addr == POWER_MODE_CONFIG_ADDR |=>
    reg_rdata_o[7:2] == 6'h00) else $error("reserved bits set");
  st_write_a: assert property (reg_req_i.wr_en && reg_req_i.addr == SELF_TEST_CONTROL_ADDR |=>
    {cfg_o.st_enable, cfg_o.st_positive, cfg_o.st_high_amp} == {$past(reg_req_i.wdata[0]),
    $past(reg_req_i.wdata[2]), $past(reg_req_i.wdata[3])}) else $error("self-test bits wrong");
endmodule : accel_config_power_regs_chk
bind accel_config_power_regs accel_config_power_regs_chk i_chk (.sys_clk_i, .resetn_i, .reg_req_i, .reg_rdata_o,
  .autoconfig_mode_i, .fifo_rd_allow_o, .cfg_o, .i2c_enable_o, .spi_enable_o, .fast_clk_en_o, .wdt_timeout_o,
  .nv_store_o, .x_offset_o);
`default_nettype wire

// [accel_config_power_regs_tb_top.sv]
// self-checking bench for the configuration register group
// drives every port itself; watchdog limits shortened to 20 and 40 cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module accel_config_power_regs_tb_top;
  import accel_cfg_pkg::*;
  logic sys_clk_i = 0, resetn_i = 0, autoconfig_mode_i = 0, serial_data_pin_i = 1;
  logic measure_busy_i = 0, fifo_irq_i = 0, fifo_rd_req_i = 0;
  reg_req_s reg_req_i = '0;
  logic [7:0] reg_rdata_o, nv_cfg_image_o, x_offset_o, y_offset_o, z_offset_o, v;
  logic [23:0] nv_image_o;
  logic fifo_rd_allow_o, i2c_enable_o, spi_enable_o, fast_clk_en_o, wdt_timeout_o, nv_store_o;
  cfg_s cfg_o;
  int mismatches = 0, samples_checked = 0, cyc = 0;
  accel_config_power_regs #(.WDT_SHORT_CYCLES(20), .WDT_LONG_CYCLES(40)) i_dut (.sys_clk_i, .resetn_i,
    .reg_req_i, .reg_rdata_o, .autoconfig_mode_i, .serial_data_pin_i, .measure_busy_i, .fifo_irq_i,
    .fifo_rd_req_i, .fifo_rd_allow_o, .cfg_o, .i2c_enable_o, .spi_enable_o, .fast_clk_en_o,
    .wdt_timeout_o, .nv_store_o, .nv_image_o, .nv_cfg_image_o, .x_offset_o, .y_offset_o, .z_offset_o);
  always #10 sys_clk_i = ~sys_clk_i;
  task automatic end_of_test;
    $display("checked %0d, wrong %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  // the whole run needs well under 1000 cycles
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : idle
  // one byte access; v holds read data once the request edge has passed
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk_i) reg_req_i <= '{w, !w, a, d};
    @(posedge sys_clk_i) reg_req_i <= '0;
    #1 v = reg_rdata_o;
  endtask : acc
  task automatic t_regs;
    logic [6:0] a[8] = '{7'h6D, 7'h70, 7'h71, 7'h72, 7'h73, 7'h7C, 7'h10, 7'h7E};
    logic [7:0] m[8] = '{8'h0D, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      acc(0, a[i], 0);
      `CHK(v, (i == 5) ? 8'h03 : 8'h00)
      acc(1, a[i], 8'hFF);
      acc(0, a[i], 0);
      `CHK(v, m[i])
      acc(1, a[i], (i == 5) ? 8'h03 : 8'h00);
    end
    $display("regs done");
  endtask : t_regs
  task automatic t_cfg;
    @(posedge sys_clk_i) autoconfig_mode_i <= 1;
    acc(1, 7'h6D, 8'h0D);
    `CHK({cfg_o.st_enable, cfg_o.st_positive, cfg_o.st_high_amp}, 3'b111)
    acc(1, 7'h6D, 8'h08);
    `CHK({cfg_o.st_enable, cfg_o.st_positive, cfg_o.st_high_amp}, 3'b001)
    acc(1, 7'h71, 8'h5A);
    acc(1, 7'h72, 8'hA5);
    acc(1, 7'h73, 8'h3C);
    `CHK({x_offset_o, y_offset_o, z_offset_o}, 24'h000000)
    acc(1, 7'h70, 8'h09);
    `CHK({spi_enable_o, i2c_enable_o, x_offset_o}, {2'b10, 8'h5A})
    `CHK({y_offset_o, z_offset_o}, 16'hA53C)
    acc(1, 7'h7E, 8'hA0);
    `CHK({nv_store_o, nv_image_o, nv_cfg_image_o}, {1'b1, 24'h3CA55A, 8'h09})
    idle(1);
    `CHK(nv_store_o, 1'b0)
    @(posedge sys_clk_i) autoconfig_mode_i <= 0;
    #1 `CHK(spi_enable_o, 1'b0)
    acc(1, 7'h70, 8'h04);
    idle(15);
    `CHK(wdt_timeout_o, 1'b0)
    idle(12);
    `CHK(wdt_timeout_o, 1'b1)
    @(posedge sys_clk_i) serial_data_pin_i <= 0;
    idle(8);
    `CHK(wdt_timeout_o, 1'b0)
    acc(1, 7'h70, 8'h06);
    `CHK({cfg_o.spi_select, cfg_o.wdt_enable, cfg_o.wdt_long, cfg_o.offset_enable}, 4'b0110)
    @(posedge sys_clk_i) serial_data_pin_i <= 1;
    idle(30);
    `CHK(wdt_timeout_o, 1'b0)
    idle(15);
    `CHK(wdt_timeout_o, 1'b1)
    acc(1, 7'h70, 8'h00);
    idle(2);
    `CHK(wdt_timeout_o, 1'b0)
    $display("config done");
  endtask : t_cfg
  task automatic t_pwr;
    `CHK(fast_clk_en_o, 1'b0)
    @(posedge sys_clk_i) measure_busy_i <= 1;
    fifo_rd_req_i <= 1;
    idle(4);
    `CHK({fast_clk_en_o, fifo_rd_allow_o}, 2'b10)
    @(posedge sys_clk_i) fifo_irq_i <= 1;
    idle(4);
    `CHK(fifo_rd_allow_o, 1'b1)
    @(posedge sys_clk_i) measure_busy_i <= 0;
    acc(1, 7'h7C, 8'h01);
    idle(4);
    `CHK({fast_clk_en_o, fifo_rd_allow_o}, 2'b00)
    `CHK({cfg_o.adv_power_save, cfg_o.fifo_self_wakeup}, 2'b10)
    acc(1, 7'h7C, 8'h00);
    `CHK({fast_clk_en_o, fifo_rd_allow_o}, 2'b11)
    @(posedge sys_clk_i) fifo_irq_i <= 0;
    idle(4);
    acc(1, 7'h7C, 8'h03);
    `CHK({fast_clk_en_o, fifo_rd_allow_o}, 2'b00)
    $display("power done");
  endtask : t_pwr
  initial begin
    repeat (10) @(posedge sys_clk_i);
    resetn_i <= 1;
    t_regs();
    t_cfg();
    t_pwr();
    end_of_test();
  end
endmodule : accel_config_power_regs_tb_top
`default_nettype wire
